/* File: pcr_pkg.sv */
// Purpose: constants and types for the power, clock and reset controller
// Assumes: core clock 100 MHz; two core clocks make one input clock period
// Notes: recovery and crystal wait counts derive from cycle figures below; divider terminal counts are fixed literals
//
// What this block does
// - leaving power-down with clock running resumes after 200 input clock cycles
// - leaving power-down with crystal stopped waits about 4096 input clock cycles
// - power-down is entered by request pin or software force bit
// - a power-down request first raises an interrupt; software then commits
// - power-down interrupt is edge-sensitive and nonmaskable
// - context control picks resume-where-stopped or cleared context on exit
// - reset while powered down ends power-down
// - acknowledge output shows the device has entered power-down
// - idle stalls until an unmasked interrupt, services it, then continues
// - cycle steals for host, byte-memory and serial transfers still granted in idle
// - slow idle divides the processor clock by 16, 32, 64 or 128
// - serial clock, cycle clock output and timer clock share the slow divisor
// - idle without a divisor is standard idle at full rate
// - slow idle may take up to n cycles to wake after an interrupt
// - instruction cycle runs at twice the input clock rate
// - cycle-rate clock output, gated by a disable bit
// - later resets keep the clock running, with no stabilisation delay
// - master reset empties stacks, masks interrupts, clears mode status
// - on release, boot if configured and no bus request, then fetch 0x0000
// - memory mode pin sampled during reset, becomes flag pin two afterwards
// - sampled zero means full memory mode, one means host mode
package pcr_pkg;
    localparam int unsigned PCR_CLK_MHZ = 100;
    localparam int unsigned PCR_RECOVER_CYC = 200;
    localparam int unsigned PCR_CRYSTAL_DRIVE_PIN_CYC = 4096;
    localparam int unsigned PCR_PLL_LOCK_CYC = 2000;
    localparam logic [12:0] PCR_RECOVER_CNT = 13'(PCR_RECOVER_CYC - 1);
    localparam logic [12:0] PCR_CRYSTAL_DRIVE_PIN_CNT = 13'(PCR_CRYSTAL_DRIVE_PIN_CYC - 1);
    localparam logic [13:0] PCR_BOOT_ADDR = 14'h0000;
    localparam logic [15:0] PCR_MODE_STATUS_REGISTER_RST = 16'h0000;
    localparam logic [15:0] PCR_IMASK_RST = 16'h0000;
    localparam logic [3:0] PCR_STACK_EMPTY = 4'h0;
    localparam int unsigned PCR_DIV_W = 7;
    // divisor codes carried by the idle instruction
    localparam logic [2:0] PCR_DIV_NONE = 3'h0;
    localparam logic [2:0] PCR_DIV_16 = 3'h1;
    localparam logic [2:0] PCR_DIV_32 = 3'h2;
    localparam logic [2:0] PCR_DIV_64 = 3'h3;
    localparam logic [2:0] PCR_DIV_128 = 3'h4;
    localparam logic [0:0] PCR_MODE_FULL = 1'h0;
    localparam logic [0:0] PCR_MODE_HOST = 1'h1;

    typedef enum logic [2:0] {
        PCR_ST_BOOT = 3'b000,
        PCR_ST_RUN = 3'b001,
        PCR_ST_IDLE = 3'b010,
        PCR_ST_PDOWN = 3'b011,
        PCR_ST_WAKE = 3'b100
    } pcr_state_e;

    // maps a divisor code to a terminal count (divisor minus one)
    function automatic logic [PCR_DIV_W-1:0] pcr_div_term(input logic [2:0] code);
        logic [PCR_DIV_W-1:0] t;
        t = 7'h00;
        case (code)
            PCR_DIV_16: t = 7'h0F;
            PCR_DIV_32: t = 7'h1F;
            PCR_DIV_64: t = 7'h3F;
            PCR_DIV_128: t = 7'h7F;
            default: t = 7'h00;
        endcase
        return t;
    endfunction
endpackage

/* File: pcr_clk_if.sv */
// Purpose: carries the slowed clock strobes from divider to controller
// Assumes: single core clock domain
// Notes: strobes are one-cycle pulses
interface pcr_clk_if;
    logic [2:0] div_code;
    logic cyc_tick;
    logic half_tick;
    logic stopped;
    modport div (input div_code, input stopped, output cyc_tick, output half_tick);
    modport ctl (output div_code, output stopped, input cyc_tick, input half_tick);
endinterface

/* File: pcr_clk_div.sv */
// Purpose: divides the processor cycle strobe for slow idle
// Assumes: div_code zero means full rate
// Notes: half_tick marks input clock periods; cyc_tick two per input period
module pcr_clk_div
    import pcr_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic nrst_in,
    pcr_clk_if.div clk_if
);
    logic [PCR_DIV_W-1:0] cnt;
    logic ph;
    wire logic [PCR_DIV_W-1:0] term = pcr_div_term(clk_if.div_code);
    wire logic wrap = (cnt == term);

    // divider counter, cleared whenever the clock is stopped
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt <= '0;
            ph <= 1'b0;
        end else if (clk_if.stopped) begin
            cnt <= '0;
        end else begin
            cnt <= wrap ? '0 : cnt + 7'h01;
            ph <= ph ^ (wrap & ~(|term));
        end
    end

    // one instruction cycle per wrap; input clock is every other cycle at full rate
    assign clk_if.cyc_tick = wrap & ~clk_if.stopped;
    assign clk_if.half_tick = wrap & ~clk_if.stopped & ph & ~(|term);
endmodule

/* File: pcr_ctrl.sv */
// Purpose: power-down, idle, slow idle, clock output and reset control
// Assumes: pins pass two flip-flops; core signals come from same clock
// Notes: recovery counts run in input clock periods
module pcr_ctrl
    import pcr_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic powerdown_request_pin_in,
    input wire logic pd_force_in,
    input wire logic pd_commit_in,
    input wire logic pd_ctx_clear_in,
    input wire logic crystal_drive_pin_off_in,
    input wire logic idle_in,
    input wire logic [2:0] idle_div_in,
    input wire logic [15:0] irq_req_in,
    input wire logic [15:0] imask_in,
    input wire logic ints_en_in,
    input wire logic steal_req_in,
    input wire logic cycle_clock_output_disable_in,
    input wire logic boot_en_in,
    input wire logic bus_req_in,
    input wire logic boot_done_in,
    input wire logic mode_c_pin_in,
    output logic pd_irq_out,
    output logic pd_ack_out,
    output logic ctx_clear_out,
    output logic run_out,
    output logic idle_out,
    output logic steal_grant_out,
    output logic cyc_tick_out,
    output logic half_tick_out,
    output logic cycle_clock_output_out,
    output logic crystal_enable_out,
    output logic [13:0] fetch_addr_out,
    output logic fetch_start_out,
    output logic boot_out,
    output logic [3:0] stack_ptr_out,
    output logic [15:0] imask_reset_out,
    output logic [15:0] mode_status_register_out,
    output logic mem_mode_out,
    output logic flag_pin_two_out
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic pd_m, pd_s, pd_d;
    logic mc_m, mc_s;
    logic [1:0] rst_sr;
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pd_m <= 1'b1;
            pd_s <= 1'b1;
            pd_d <= 1'b1;
        end else begin
            pd_m <= powerdown_request_pin_in;
            pd_s <= pd_m;
            pd_d <= pd_s;
        end
    end

    // mode pin sync has no reset, so the level driven during reset reaches the capture
    always_ff @(posedge core_clk_in) begin
        mc_m <= mode_c_pin_in;
        mc_s <= mc_m;
    end

    // release stretcher: held low through reset, high two edges later
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_sr <= 2'b00;
        end else begin
            rst_sr <= {rst_sr[0], 1'b1};
        end
    end
    wire logic in_reset = ~rst_sr[1];

    // ------------------------------------------------------------
    // clock divider
    // ------------------------------------------------------------
    pcr_clk_if clk_if();
    pcr_clk_div u_div (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .clk_if(clk_if)
    );

    pcr_state_e state, next_state;
    logic [2:0] div_code;
    logic [12:0] wait_cnt;
    logic wait_long, wait_ph;
    logic pd_pend;
    logic cko;
    logic mem_mode;
    logic [15:0] mode_status_register;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic pd_fall = pd_d & ~pd_s; // active-low pin edge
    wire logic pd_event = (pd_fall | pd_force_in) & (state != PCR_ST_PDOWN); // wake event raises nothing
    wire logic any_irq = |(irq_req_in & imask_in) & ints_en_in;
    wire logic wake_irq = any_irq | pd_pend;
    wire logic [12:0] wait_term = wait_long ? PCR_CRYSTAL_DRIVE_PIN_CNT : PCR_RECOVER_CNT;
    wire logic wait_done = (wait_cnt == wait_term) & wait_ph;
    wire logic boot_wait = boot_en_in & ~bus_req_in;

    assign clk_if.div_code = (state == PCR_ST_IDLE) ? div_code : PCR_DIV_NONE;
    assign clk_if.stopped = (state == PCR_ST_PDOWN) | (state == PCR_ST_WAKE);

    // ------------------------------------------------------------
    // power-down interrupt latch, set wins over clear
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pd_pend <= 1'b0;
        end else if (pd_event) begin
            pd_pend <= 1'b1;
        end else if (pd_commit_in || state == PCR_ST_PDOWN) begin
            pd_pend <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            PCR_ST_BOOT: begin
                if (!in_reset && (!boot_wait || boot_done_in)) begin
                    next_state = PCR_ST_RUN;
                end
            end
            PCR_ST_RUN: begin
                if (pd_commit_in && pd_pend) begin
                    next_state = PCR_ST_PDOWN;
                end else if (idle_in) begin
                    next_state = PCR_ST_IDLE;
                end
            end
            PCR_ST_IDLE: begin
                if (wake_irq && clk_if.cyc_tick) begin
                    next_state = PCR_ST_RUN;
                end
            end
            PCR_ST_PDOWN: begin
                if (pd_fall || pd_force_in) begin
                    next_state = PCR_ST_WAKE;
                end
            end
            PCR_ST_WAKE: begin
                if (wait_done) begin
                    next_state = PCR_ST_RUN;
                end
            end
            default: next_state = PCR_ST_BOOT;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= PCR_ST_BOOT;
        end else begin
            state <= next_state;
        end
    end

    // idle divisor captured when idle is entered
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            div_code <= PCR_DIV_NONE;
        end else if (state == PCR_ST_RUN && idle_in) begin
            div_code <= idle_div_in;
        end
    end

    // recovery counter, steps once per input clock period
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wait_cnt <= '0;
            wait_long <= 1'b0;
            wait_ph <= 1'b0;
        end else if (state == PCR_ST_PDOWN) begin
            wait_cnt <= '0;
            wait_long <= crystal_drive_pin_off_in;
            wait_ph <= 1'b0;
        end else if (state == PCR_ST_WAKE && !wait_done) begin
            wait_ph <= ~wait_ph;
            wait_cnt <= wait_cnt + {12'h000, wait_ph};
        end
    end

    // cycle clock output toggles on every divided cycle strobe unless the disable bit holds it low
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cko <= 1'b0;
        end else if (cycle_clock_output_disable_in) begin
            cko <= 1'b0;
        end else if (clk_if.cyc_tick) begin
            cko <= ~cko;
        end
    end

    // mode pin captured while reset holds, pin becomes flag two after
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mem_mode <= PCR_MODE_FULL;
        end else if (in_reset) begin
            mem_mode <= mc_s;
        end
    end

    // mode status cleared by reset and on cleared-context wake
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mode_status_register <= PCR_MODE_STATUS_REGISTER_RST;
        end else if (state == PCR_ST_WAKE && wait_done && pd_ctx_clear_in) begin
            mode_status_register <= PCR_MODE_STATUS_REGISTER_RST;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign pd_irq_out = pd_pend;
    assign pd_ack_out = (state == PCR_ST_PDOWN) | (state == PCR_ST_WAKE);
    assign ctx_clear_out = (state == PCR_ST_WAKE) & wait_done & pd_ctx_clear_in;
    assign run_out = (state == PCR_ST_RUN);
    assign idle_out = (state == PCR_ST_IDLE);
    assign steal_grant_out = steal_req_in & ((state == PCR_ST_RUN) | (state == PCR_ST_IDLE));
    assign cyc_tick_out = clk_if.cyc_tick;
    assign half_tick_out = clk_if.half_tick;
    assign cycle_clock_output_out = cko;
    assign crystal_enable_out = ~((state == PCR_ST_PDOWN) & crystal_drive_pin_off_in);
    assign fetch_addr_out = PCR_BOOT_ADDR;
    assign fetch_start_out = (state == PCR_ST_BOOT) & (next_state == PCR_ST_RUN);
    assign boot_out = (state == PCR_ST_BOOT) & ~in_reset & boot_wait;
    assign stack_ptr_out = PCR_STACK_EMPTY;
    assign imask_reset_out = PCR_IMASK_RST;
    assign mode_status_register_out = mode_status_register;
    assign mem_mode_out = mem_mode;
    assign flag_pin_two_out = in_reset ? 1'b0 : mc_s;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_pd_entry;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (state == PCR_ST_RUN && pd_commit_in && pd_pend) |=> pd_ack_out;
    endproperty
    a_pd_entry: assert property (p_pd_entry) else $error("ack missing after commit");

    property p_recover;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (state == PCR_ST_PDOWN && !crystal_drive_pin_off_in && (pd_fall || pd_force_in)) |=> (state == PCR_ST_WAKE)[*8] ##[1:400] run_out;
    endproperty
    a_recover: assert property (p_recover) else $error("recovery not in 200 cycles");

    property p_crystal_drive_pin_wait;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (state == PCR_ST_WAKE && wait_long && wait_cnt < PCR_CRYSTAL_DRIVE_PIN_CNT) |=> !run_out;
    endproperty
    a_crystal_drive_pin_wait: assert property (p_crystal_drive_pin_wait) else $error("crystal wait cut short");

    property p_pd_edge;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (pd_fall && !pd_force_in && state != PCR_ST_PDOWN) |=> pd_pend;
    endproperty
    a_pd_edge: assert property (p_pd_edge) else $error("power-down edge lost");

    property p_no_direct_pd;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (state == PCR_ST_RUN && !pd_commit_in) |=> !pd_ack_out;
    endproperty
    a_no_direct_pd: assert property (p_no_direct_pd) else $error("entered power-down uncommitted");

    property p_slow_wake;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (idle_out && any_irq && div_code == PCR_DIV_128) |-> ##[0:255] !idle_out;
    endproperty
    a_slow_wake: assert property (p_slow_wake) else $error("slow idle wake too late");

    property p_std_idle;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (idle_out && div_code == PCR_DIV_NONE) |-> clk_if.cyc_tick;
    endproperty
    a_std_idle: assert property (p_std_idle) else $error("standard idle slowed");

    property p_cko_gate;
        @(posedge core_clk_in) disable iff (!nrst_in)
        cycle_clock_output_disable_in |=> !cycle_clock_output_out;
    endproperty
    a_cko_gate: assert property (p_cko_gate) else $error("clock output not gated");

    property p_mode_hold;
        @(posedge core_clk_in) disable iff (!nrst_in)
        !in_reset |=> $stable(mem_mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("memory mode changed after reset");

    property p_steal;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (idle_out && steal_req_in) |-> steal_grant_out;
    endproperty
    a_steal: assert property (p_steal) else $error("steal refused in idle");
endmodule

/* File: pcr_far_model.sv */
// Purpose: far-side model of the power-down pin driver and the memory mode pin driver
// Assumes: the power-down pin has a pull-up and rests high when not driven
// Notes: the mode driver lets go a few cycles after reset and the line then floats away
module pcr_far_model
(
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic pin_pulse_in,
    input wire logic mode_level_in,
    output logic powerdown_request_pin_out,
    output logic mode_c_pin_out
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PULSE_CYC = 24;
    localparam int GAP_CYC = 8;
    int pin_cnt = 0;
    int hold_cnt = 0;

    // ----------------------------------------
    // power-down pin
    // ----------------------------------------
    // low for a fixed span, then a quiet gap so requests never come faster than service
    always_ff @(posedge core_clk_in) begin
        if (pin_cnt > 0) begin
            pin_cnt <= pin_cnt - 1;
        end else if (pin_pulse_in) begin
            pin_cnt <= PULSE_CYC + GAP_CYC;
        end
    end
    assign powerdown_request_pin_out = !(pin_cnt > GAP_CYC); // pull-up when released

    // ----------------------------------------
    // memory mode pin
    // ----------------------------------------
    // driven during reset and a short hold after, then shows the inverse level
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            hold_cnt <= 6;
        end else if (hold_cnt > 0) begin
            hold_cnt <= hold_cnt - 1;
        end
    end
    assign mode_c_pin_out = (hold_cnt > 0) ? mode_level_in : !mode_level_in;
endmodule

/* File: dsp_power_clock_reset_control_tb.sv */
// Purpose: self-checking bench for the power, clock and reset controller
// Assumes: one core clock domain at 100 MHz
// Notes: counts of ticks and toggles are kept by a monitor and compared as deltas
module dsp_power_clock_reset_control_tb
    import pcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk_in, nrst_in, pd_force, pd_commit, ctx_clr, crystal_drive_pin_off, idle, steal_req, ck_dis;
    logic boot_en, bus_req, boot_done, ints_en, pin_pulse, mode_level, pd_pin, mode_pin;
    logic [2:0] idle_div;
    logic [15:0] irq_req, imask, imask_rst, mode_status_register;
    logic pd_irq, pd_ack, ctx_pulse, run, idl, grant, cyc_tick, half_tick, ccout, crystal_drive_pin_en;
    logic fetch_start, boot, mem_mode, flag2, ccprev;
    logic [13:0] fetch_addr;
    logic [3:0] stack_ptr;
    int errors = 0;
    int tests_run = 0;
    int ticks = 0, halves = 0, togs = 0, ctxs = 0, fstarts = 0;

    pcr_far_model far (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .pin_pulse_in(pin_pulse),
        .mode_level_in(mode_level), .powerdown_request_pin_out(pd_pin), .mode_c_pin_out(mode_pin));

    pcr_ctrl dut (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .powerdown_request_pin_in(pd_pin),
        .pd_force_in(pd_force), .pd_commit_in(pd_commit), .pd_ctx_clear_in(ctx_clr), .crystal_drive_pin_off_in(crystal_drive_pin_off),
        .idle_in(idle), .idle_div_in(idle_div), .irq_req_in(irq_req), .imask_in(imask), .ints_en_in(ints_en),
        .steal_req_in(steal_req), .cycle_clock_output_disable_in(ck_dis), .boot_en_in(boot_en),
        .bus_req_in(bus_req), .boot_done_in(boot_done), .mode_c_pin_in(mode_pin), .pd_irq_out(pd_irq),
        .pd_ack_out(pd_ack), .ctx_clear_out(ctx_pulse), .run_out(run), .idle_out(idl),
        .steal_grant_out(grant), .cyc_tick_out(cyc_tick), .half_tick_out(half_tick),
        .cycle_clock_output_out(ccout), .crystal_enable_out(crystal_drive_pin_en), .fetch_addr_out(fetch_addr),
        .fetch_start_out(fetch_start), .boot_out(boot), .stack_ptr_out(stack_ptr),
        .imask_reset_out(imask_rst), .mode_status_register_out(mode_status_register), .mem_mode_out(mem_mode),
        .flag_pin_two_out(flag2));

    // ----------------------------------------
    // clock and monitor
    // ----------------------------------------
    // free-running clock, never stopped or altered
    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = !core_clk_in;
    end
    // counts pulses and clock output toggles for span checks
    always @(posedge core_clk_in) begin
        if (cyc_tick === 1'b1) ticks++;
        if (half_tick === 1'b1) halves++;
        if (ccout !== ccprev) togs++;
        if (ctx_pulse === 1'b1) ctxs++;
        if (fetch_start === 1'b1) fstarts++;
        ccprev = ccout;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic print_verdict;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t: %s", $time, m);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi, input string m);
        tests_run++;
        if (got < lo || got > hi) begin
            errors++;
            $display("Error %0t: %s got %0d", $time, m, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask
    // one-cycle pulse on a core strobe
    task automatic pulse(input int s);
        @(posedge core_clk_in);
        case (s)
            0: pd_force <= 1'b1;
            1: pd_commit <= 1'b1;
            2: idle <= 1'b1;
            3: pin_pulse <= 1'b1;
            default: boot_done <= 1'b1;
        endcase
        @(posedge core_clk_in);
        {pd_force, pd_commit, idle, pin_pulse, boot_done} <= 5'h00;
        #1;
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: return pd_irq;
            1: return pd_ack;
            2: return run;
            default: return cyc_tick;
        endcase
    endfunction
    // bounded wait for an output level, k is the cycles spent
    task automatic wt(input int s, input logic v, input int max, output int k);
        k = 0;
        while (pick(s) !== v && k < max) begin
            cyc(1);
            k++;
        end
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_boot;
        int k, f0;
        cyc(10);
        chk(boot, 1'b1, "boot not held");
        chk(run, 1'b0, "ran before boot done");
        f0 = fstarts;
        pulse(4);
        wt(2, 1'b1, 10, k);
        chk(run, 1'b1, "no run after boot");
        chk_rng(fstarts - f0, 1, 1, "fetch start count");
        chk({2'h0, fetch_addr}, 16'h0000, "fetch address");
        chk(stack_ptr, 16'h0000, "stack not empty");
        chk(imask_rst, 16'h0000, "interrupts not masked");
        chk(mode_status_register, 16'h0000, "mode status not clear");
        chk(mem_mode, 1'b1, "host mode not taken");
        chk(flag2, 1'b0, "flag pin does not follow pin");
    endtask
    task automatic t_cycle_clock_output;
        int t0, h0, g0;
        t0 = ticks;
        h0 = halves;
        g0 = togs;
        cyc(8);
        chk_rng(ticks - t0, 8, 8, "cycle ticks");
        chk_rng(halves - h0, 4, 4, "input periods");
        chk_rng(togs - g0, 8, 8, "clock output toggles");
        @(posedge core_clk_in);
        ck_dis <= 1'b1;
        cyc(3);
        g0 = togs;
        cyc(8);
        chk_rng(togs - g0, 0, 0, "gated clock toggles");
        chk(ccout, 1'b0, "gated clock level");
        @(posedge core_clk_in);
        ck_dis <= 1'b0;
        pulse(1);
        cyc(5);
        chk(pd_ack, 1'b0, "commit without request");
        chk(run, 1'b1, "stopped without request");
    endtask
    task automatic t_force;
        int k, c0;
        c0 = ctxs;
        pulse(0);
        wt(0, 1'b1, 6, k);
        chk(pd_irq, 1'b1, "force gave no request");
        chk(run, 1'b1, "stopped before commit");
        pulse(1);
        wt(1, 1'b1, 4, k);
        chk(pd_ack, 1'b1, "no acknowledge");
        chk(run, 1'b0, "running in power-down");
        chk(pd_irq, 1'b0, "request not cleared");
        chk(crystal_drive_pin_en, 1'b1, "crystal stopped");
        cyc(20);
        pulse(0);
        wt(2, 1'b1, 9000, k);
        chk_rng(k, 2 * PCR_RECOVER_CYC, 408, "recovery span");
        chk(pd_ack, 1'b0, "acknowledge stuck");
        chk_rng(ctxs - c0, 0, 0, "clear on resume");
    endtask
    task automatic t_pin;
        int k, c0;
        @(posedge core_clk_in);
        ctx_clr <= 1'b1;
        crystal_drive_pin_off <= 1'b1;
        c0 = ctxs;
        pulse(3);
        wt(0, 1'b1, 8, k);
        chk(pd_irq, 1'b1, "pin gave no request");
        pulse(1);
        wt(1, 1'b1, 4, k);
        cyc(5);
        chk(pd_irq, 1'b0, "low pin raised again");
        chk(crystal_drive_pin_en, 1'b0, "crystal kept");
        cyc(30);
        pulse(3);
        wt(2, 1'b1, 9000, k);
        chk_rng(k, 2 * PCR_CRYSTAL_DRIVE_PIN_CYC, 8208, "crystal wait");
        chk_rng(ctxs - c0, 1, 1, "context clear pulse");
        chk(mode_status_register, 16'h0000, "status after clear");
        @(posedge core_clk_in);
        ctx_clr <= 1'b0;
        crystal_drive_pin_off <= 1'b0;
    endtask
    task automatic t_idle;
        int k, t0;
        pulse(2);
        @(posedge core_clk_in);
        steal_req <= 1'b1;
        irq_req <= 16'h0004;
        ints_en <= 1'b1;
        cyc(5);
        chk(idl, 1'b1, "woke on masked request");
        chk(grant, 1'b1, "steal refused in idle");
        t0 = ticks;
        cyc(8);
        chk_rng(ticks - t0, 8, 8, "standard idle rate");
        @(posedge core_clk_in);
        imask <= 16'h0004;
        wt(2, 1'b1, 4, k);
        chk(run, 1'b1, "no wake on unmasked");
        @(posedge core_clk_in);
        irq_req <= 16'h0000;
        steal_req <= 1'b0;
    endtask
    task automatic t_slow;
        int k, n, t0, g0;
        for (int c = 1; c <= 4; c++) begin
            n = 8 << c;
            @(posedge core_clk_in);
            idle_div <= 3'(c);
            pulse(2);
            wt(3, 1'b1, 300, k);
            cyc(1);
            t0 = ticks;
            g0 = togs;
            cyc(4 * n);
            chk_rng(ticks - t0, 4, 4, "slow cycle ticks");
            chk_rng(togs - g0, 4, 4, "slow clock output");
            @(posedge core_clk_in);
            irq_req <= 16'h0004;
            wt(2, 1'b1, n + 4, k);
            chk(run, 1'b1, "slow wake late");
            @(posedge core_clk_in);
            irq_req <= 16'h0000;
        end
        idle_div <= 3'h0;
    endtask
    task automatic t_reset_pd;
        int k, t0;
        pulse(0);
        wt(0, 1'b1, 6, k);
        pulse(1);
        wt(1, 1'b1, 4, k);
        @(posedge core_clk_in);
        nrst_in <= 1'b0;
        mode_level <= 1'b0;
        bus_req <= 1'b1;
        cyc(3);
        chk(pd_ack, 1'b0, "reset kept power-down");
        @(posedge core_clk_in);
        nrst_in <= 1'b1;
        wt(2, 1'b1, 20, k);
        chk(run, 1'b1, "slow restart");
        chk(boot, 1'b0, "booted with bus request");
        chk(mem_mode, 1'b0, "full mode not taken");
        t0 = ticks;
        cyc(4);
        chk_rng(ticks - t0, 4, 4, "clock after reset");
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        {pd_force, pd_commit, ctx_clr, crystal_drive_pin_off, idle, steal_req, ck_dis} = 7'h00;
        {bus_req, boot_done, ints_en, pin_pulse} = 4'h0;
        {boot_en, mode_level} = 2'h3;
        idle_div = 3'h0;
        irq_req = 16'h0000;
        imask = 16'h0000;
        nrst_in = 1'b0;
        cyc(1);
        chk(flag2, 1'b0, "flag pin in reset");
        @(posedge core_clk_in);
        nrst_in <= 1'b1; // short power-up hold: no oscillator or loop lock is modelled
        t_boot;
        t_cycle_clock_output;
        t_force;
        t_pin;
        t_idle;
        t_slow;
        t_reset_pd;
        print_verdict;
    end
    initial begin
        #500000;
        errors++;
        print_verdict;
    end
endmodule
